// >>> common/sts_params.svh
// Timing defaults and phase count for the source transfer sequencer
`ifndef STS_PARAMS_SVH
`define STS_PARAMS_SVH
`define STS_CLK_HZ            25000000
`define STS_PHASES            3
`define STS_START_DLY_MS      3
`define STS_STANDBY_DLY_MS    1
`define STS_RETURN_DLY_MS     300
`define STS_COOL_DLY_MS       300
`define STS_MS_CYCLES(ms)     ((ms) * (`STS_CLK_HZ / 1000))
`define STS_OPEN_GAP_CYCLES   4
`endif

// >>> common/sts_pkg.sv
// Types shared by the source transfer sequencer
package sts_pkg;
  typedef enum logic [2:0] {
    STS_IDLE     = 3'b000,
    STS_START    = 3'b001,
    STS_WAIT_EM  = 3'b010,
    STS_STANDBY  = 3'b011,
    STS_ON_EM    = 3'b100,
    STS_RETURN   = 3'b101,
    STS_COOL     = 3'b110
  } sts_state_t;

  // Switch commands: at most one of the two close outputs is high
  typedef struct packed {
    logic close_normal;
    logic close_emergency;
  } sts_switch_t;
endpackage

// >>> src/sts_sequencer.sv
// Source transfer sequencer: source judging, delay timers, generator and switch control
`timescale 1ns/10ps
`include "sts_params.svh"

// Behaviour
// RQ1: Source acceptable only if all phases in-window
// RQ2: Any phase out of window means failed
// RQ3: All phases back in window means restored
// RQ4: Normal failure starts engine start delay
// RQ5: Restore during start delay clears, no start
// RQ6: Start delay done, still failed: start generator
// RQ7: Emergency acceptable after start begins standby delay
// RQ8: Standby delay done: connect load to emergency
// RQ9: Load stays on emergency until return done
// RQ10: Normal restored on emergency starts return delay
// RQ11: Normal fails during return: clear, stay
// RQ12: Return done, normal steady: reconnect normal
// RQ13: Back on normal, cooldown runs generator unloaded
// RQ14: Cooldown expiry drops generator start
// RQ15: At power-on, run generator through cooldown
// RQ16: Never both closed; open before close
// RQ17: Four delays as cycle parameters, count from zero
module sts_sequencer
  import sts_pkg::*;
#(
  parameter int PHASES     = `STS_PHASES,
  parameter int START_CYC  = `STS_MS_CYCLES(`STS_START_DLY_MS),
  parameter int STBY_CYC   = `STS_MS_CYCLES(`STS_STANDBY_DLY_MS),
  parameter int RETURN_CYC = `STS_MS_CYCLES(`STS_RETURN_DLY_MS),
  parameter int COOL_CYC   = `STS_MS_CYCLES(`STS_COOL_DLY_MS),
  parameter int GAP_CYC    = `STS_OPEN_GAP_CYCLES
)(
  input  wire logic              clk_in,
  input  wire logic              rstn_in,
  input  wire logic [PHASES-1:0] norm_volt_ok_in,
  input  wire logic [PHASES-1:0] norm_freq_ok_in,
  input  wire logic [PHASES-1:0] emer_volt_ok_in,
  input  wire logic [PHASES-1:0] emer_freq_ok_in,
  output logic                   gen_start_out,
  output sts_switch_t            switch_out,
  output logic                   norm_ok_out,
  output logic                   emer_ok_out,
  output sts_state_t             state_out
);

  localparam int TW = 32;

  // Acceptance: every sensed phase must pass both checks
  function automatic logic src_ok(input logic [PHASES-1:0] v, input logic [PHASES-1:0] f);
    src_ok = &(v & f);
  endfunction

  sts_state_t      state_q;
  logic [TW-1:0]   tmr_q;
  logic            norm_ok;
  logic            emer_ok;
  logic            want_emer;    // Target position of the load
  logic [TW-1:0]   gap_q;
  sts_switch_t     sw_q;
  logic            gen_q;
  logic            tmr_done;
  logic [TW-1:0]   tmr_lim;

  // RQ1 judging of both sources
  // RQ2 any failing phase drops the flag
  // RQ3 restored as soon as all phases pass again
  assign norm_ok = src_ok(norm_volt_ok_in, norm_freq_ok_in);
  assign emer_ok = src_ok(emer_volt_ok_in, emer_freq_ok_in);

  // Limit for the timer of the current state
  always_comb
  begin
    case (state_q)
      STS_START:   tmr_lim = TW'(START_CYC);
      STS_STANDBY: tmr_lim = TW'(STBY_CYC);
      STS_RETURN:  tmr_lim = TW'(RETURN_CYC);
      STS_COOL:    tmr_lim = TW'(COOL_CYC);
      default:     tmr_lim = '1;
    endcase
  end

  // RQ17 timer expires after the parameter count
  assign tmr_done = (tmr_q >= tmr_lim - TW'(1));

  // Sequence control; timer restarts at zero on every state change
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      // RQ15 power-on begins in cooldown with generator running
      state_q <= STS_COOL;
      tmr_q   <= '0;
    end
    else
    begin
      tmr_q <= tmr_q + TW'(1);
      case (state_q)
        STS_IDLE:
        begin
          // RQ4 normal failure starts engine start delay
          if (!norm_ok)
          begin
            state_q <= STS_START;
            tmr_q   <= '0;
          end
        end
        STS_START:
        begin
          // RQ5 restore clears the timer, no start issued
          if (norm_ok)
          begin
            state_q <= STS_IDLE;
            tmr_q   <= '0;
          end
          // RQ6 delay complete with normal still failed
          else if (tmr_done)
          begin
            state_q <= STS_WAIT_EM;
            tmr_q   <= '0;
          end
        end
        STS_WAIT_EM:
        begin
          // RQ7 acceptable emergency starts standby delay
          if (emer_ok)
          begin
            state_q <= STS_STANDBY;
            tmr_q   <= '0;
          end
        end
        STS_STANDBY:
        begin
          // An unstable generator restarts the wait
          if (!emer_ok)
          begin
            state_q <= STS_WAIT_EM;
            tmr_q   <= '0;
          end
          // RQ8 transfer to emergency
          else if (tmr_done)
          begin
            state_q <= STS_ON_EM;
            tmr_q   <= '0;
          end
        end
        STS_ON_EM:
        begin
          // RQ10 normal restored starts return delay
          if (norm_ok)
          begin
            state_q <= STS_RETURN;
            tmr_q   <= '0;
          end
        end
        STS_RETURN:
        begin
          // RQ11 normal fails again: clear, load stays put
          if (!norm_ok)
          begin
            state_q <= STS_ON_EM;
            tmr_q   <= '0;
          end
          // RQ12 return delay done with normal steady
          else if (tmr_done)
          begin
            state_q <= STS_COOL;
            tmr_q   <= '0;
          end
        end
        STS_COOL:
        begin
          // RQ14 cooldown expiry ends the run
          if (tmr_done)
          begin
            state_q <= norm_ok ? STS_IDLE : STS_START;
            tmr_q   <= '0;
          end
        end
        default:
        begin
          state_q <= STS_IDLE;
          tmr_q   <= '0;
        end
      endcase
    end
  end

  // RQ9 load target follows only the emergency holding states
  assign want_emer = (state_q == STS_ON_EM) || (state_q == STS_RETURN);

  // Generator run command
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      gen_q <= 1'b1;
    else
      // RQ13 generator keeps running through cooldown
      gen_q <= (state_q != STS_IDLE) && (state_q != STS_START);
  end

  // RQ16 break before make: open both, wait a gap, then close target
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      sw_q  <= '0;
      gap_q <= '0;
    end
    else if ((sw_q.close_emergency && !want_emer) || (sw_q.close_normal && want_emer))
    begin
      sw_q  <= '0;
      gap_q <= '0;
    end
    else if (!sw_q.close_emergency && !sw_q.close_normal)
    begin
      if (gap_q >= TW'(GAP_CYC))
      begin
        sw_q.close_emergency <= want_emer;
        sw_q.close_normal    <= !want_emer;
      end
      else
        gap_q <= gap_q + TW'(1);
    end
  end

  assign gen_start_out = gen_q;
  assign switch_out    = sw_q;
  assign norm_ok_out   = norm_ok;
  assign emer_ok_out   = emer_ok;
  assign state_out     = state_q;

  // Assertions
  start_clears_a: assert property (@(posedge clk_in) disable iff (!rstn_in) // RQ5
    (state_q == STS_START && norm_ok) |=> state_q == STS_IDLE)
    else $error("start delay not cleared on restore");

  fail_starts_a: assert property (@(posedge clk_in) disable iff (!rstn_in) // RQ4
    (state_q == STS_IDLE && !norm_ok) |=> (state_q == STS_START && tmr_q == '0))
    else $error("failure did not start delay");

  gen_start_a: assert property (@(posedge clk_in) disable iff (!rstn_in) // RQ6
    (state_q == STS_START && !norm_ok && tmr_done) |=> ##1 gen_start_out)
    else $error("generator not started");

  standby_go_a: assert property (@(posedge clk_in) disable iff (!rstn_in) // RQ7
    (state_q == STS_WAIT_EM && emer_ok) |=> state_q == STS_STANDBY)
    else $error("standby delay not started");

  to_emer_a: assert property (@(posedge clk_in) disable iff (!rstn_in) // RQ8
    (state_q == STS_STANDBY && emer_ok && tmr_done) |=> want_emer)
    else $error("no transfer to emergency");

  return_reset_a: assert property (@(posedge clk_in) disable iff (!rstn_in) // RQ11
    (state_q == STS_RETURN && !norm_ok) |=> (state_q == STS_ON_EM && want_emer))
    else $error("return delay not cleared");

  not_both_a: assert property (@(posedge clk_in) disable iff (!rstn_in) // RQ16
    !(switch_out.close_normal && switch_out.close_emergency))
    else $error("both switches closed");

  open_first_a: assert property (@(posedge clk_in) disable iff (!rstn_in) // RQ16
    $rose(switch_out.close_emergency) |->
      (!$past(switch_out.close_normal) && !$past(switch_out.close_normal, 2)))
    else $error("closed without opening first");

  norm_first_a: assert property (@(posedge clk_in) disable iff (!rstn_in) // RQ16
    $rose(switch_out.close_normal) |->
      (!$past(switch_out.close_emergency) && !$past(switch_out.close_emergency, 2)))
    else $error("normal closed without opening first");

  cool_stop_a: assert property (@(posedge clk_in) disable iff (!rstn_in) // RQ14
    (state_q == STS_COOL && tmr_done && norm_ok) |=> ##1 !gen_start_out)
    else $error("generator not stopped after cooldown");

  // Transfer steps: a closed switch opens, then both stay open a while
  sequence both_open_s;
    !switch_out.close_normal && !switch_out.close_emergency;
  endsequence

  sequence norm_opens_s;
    switch_out.close_normal ##1 !switch_out.close_normal;
  endsequence

  sequence emer_opens_s;
    switch_out.close_emergency ##1 !switch_out.close_emergency;
  endsequence

  norm_gap_a: assert property (@(posedge clk_in) disable iff (!rstn_in) // RQ16
    norm_opens_s |-> both_open_s [*2])
    else $error("no open gap after normal opened");

  emer_gap_a: assert property (@(posedge clk_in) disable iff (!rstn_in) // RQ16
    emer_opens_s |-> both_open_s [*2])
    else $error("no open gap after emergency opened");

  return_go_a: assert property (@(posedge clk_in) disable iff (!rstn_in) // RQ10
    (state_q == STS_ON_EM && norm_ok) |=> (state_q == STS_RETURN && tmr_q == '0))
    else $error("return delay not started");

  back_normal_a: assert property (@(posedge clk_in) disable iff (!rstn_in) // RQ12
    (state_q == STS_RETURN && norm_ok && tmr_done) |=> (state_q == STS_COOL && !want_emer))
    else $error("load not sent back to normal");

  hold_emer_a: assert property (@(posedge clk_in) disable iff (!rstn_in) // RQ9
    (want_emer && !(state_q == STS_RETURN && norm_ok && tmr_done)) |=> want_emer)
    else $error("load left emergency early");

  cool_runs_a: assert property (@(posedge clk_in) disable iff (!rstn_in) // RQ13
    (state_q == STS_COOL) |=> gen_start_out)
    else $error("generator stopped during cooldown");

  tmr_zero_a: assert property (@(posedge clk_in) disable iff (!rstn_in) // RQ17
    (state_q != $past(state_q)) |-> (tmr_q == '0))
    else $error("timer not restarted on state change");

endmodule

// >>> test/sts_gen_model.sv
// Generator model: emergency source comes up a while after the run command
`timescale 1ns/10ps
module sts_gen_model #(
  parameter int PHASES  = 3,
  parameter int SPIN_UP = 3
)(
  input  wire logic              clk_in,
  input  wire logic              run_in,
  output logic [PHASES-1:0]      volt_ok_out,
  output logic [PHASES-1:0]      freq_ok_out
);
  int spin_q = 0;

  // Engine needs time to spin up; stopping drops the output at once
  always @(posedge clk_in)
  begin
    spin_q <= run_in ? ((spin_q < SPIN_UP) ? spin_q + 1 : spin_q) : 0;
  end

  // Both voltage and frequency settle together
  assign volt_ok_out = (spin_q == SPIN_UP) ? '1 : '0;
  assign freq_ok_out = volt_ok_out;
endmodule

// >>> test/source_transfer_sequencer_test.sv
// Testbench for the source transfer sequencer
`timescale 1ns/10ps
module source_transfer_sequencer_test
  import sts_pkg::*;
;
  localparam int ST = 6, SB = 5, RT = 8, CL = 7, GP = 4;
  logic        clk_in = 0;
  logic        rstn_in = 0;
  logic [2:0]  nv = 3'h7, nf = 3'h7, ev, ef;
  logic        gen_start_out, norm_ok_out, emer_ok_out;
  sts_switch_t switch_out;
  sts_state_t  state_out;
  int          mismatches = 0;
  int          check_count = 0;

  always #20 clk_in = ~clk_in;

  sts_sequencer #(.START_CYC(ST), .STBY_CYC(SB), .RETURN_CYC(RT), .COOL_CYC(CL),
    .GAP_CYC(GP)) i_sts_sequencer (.clk_in(clk_in), .rstn_in(rstn_in),
    .norm_volt_ok_in(nv), .norm_freq_ok_in(nf), .emer_volt_ok_in(ev),
    .emer_freq_ok_in(ef), .gen_start_out(gen_start_out), .switch_out(switch_out),
    .norm_ok_out(norm_ok_out), .emer_ok_out(emer_ok_out), .state_out(state_out));

  sts_gen_model i_sts_gen_model (.clk_in(clk_in), .run_in(gen_start_out),
    .volt_ok_out(ev), .freq_ok_out(ef));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Bounded wait for a state, then judge it
  task automatic wait_st(input sts_state_t s, input int lim);
    int n;
    n = 0;
    while (state_out !== s && n < lim)
    begin
      @(negedge clk_in);
      n++;
    end
    check({5'h0, state_out}, {5'h0, s});
  endtask

  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Both switches closed is never legal, look every cycle
  always @(negedge clk_in)
    if (rstn_in)
      check({7'h0, switch_out === 2'b11}, 8'h00);

  task automatic power_on();
    check({7'h0, gen_start_out}, 8'h01);
    wait_st(STS_IDLE, CL + 3);
    @(negedge clk_in);
    check({5'h0, switch_out, gen_start_out}, 8'h04);
  endtask

  // Any single phase out of window fails the source, restore before start
  task automatic short_outage();
    for (int i = 0; i < 6; i++)
    begin
      {nf, nv} = ~(6'h01 << i);
      @(negedge clk_in);
      check({7'h0, norm_ok_out}, 8'h00);
      wait_st(STS_START, 3);
      repeat (ST - 4) @(negedge clk_in);
      {nf, nv} = 6'h3f;
      wait_st(STS_IDLE, 3);
      check({6'h0, norm_ok_out, gen_start_out}, 8'h02);
    end
  endtask

  task automatic full_cycle();
    nv = 3'h5;
    wait_st(STS_START, 3);
    repeat (ST - 2) @(negedge clk_in);
    check({5'h0, state_out}, {5'h0, STS_START});
    wait_st(STS_WAIT_EM, 3);
    @(negedge clk_in);
    check({7'h0, gen_start_out}, 8'h01);
    wait_st(STS_STANDBY, 8);
    wait_st(STS_ON_EM, SB + 2);
    repeat (GP + 4) @(negedge clk_in);
    check({6'h0, switch_out}, 8'h01);
    nv = 3'h7;
    wait_st(STS_RETURN, 3);
    repeat (RT - 3) @(negedge clk_in);
    nf = 3'h3;
    wait_st(STS_ON_EM, 3);
    check({6'h0, switch_out}, 8'h01);
    nf = 3'h7;
    wait_st(STS_RETURN, 3);
    wait_st(STS_COOL, RT + 2);
    repeat (GP + 2) @(negedge clk_in);
    check({5'h0, switch_out, gen_start_out}, 8'h05);
    wait_st(STS_IDLE, CL + 2);
    @(negedge clk_in);
    check({7'h0, gen_start_out}, 8'h00);
  endtask

  // Reset while idle on normal opens both switches and restarts the cooldown run
  task automatic mid_reset();
    rstn_in = 0;
    @(negedge clk_in);
    check({5'h0, switch_out, gen_start_out}, 8'h01);
    check({5'h0, state_out}, {5'h0, STS_COOL});
    rstn_in = 1;
    wait_st(STS_IDLE, CL + 3);
    @(negedge clk_in);
    check({5'h0, switch_out, gen_start_out}, 8'h04);
  endtask

  initial
  begin
    #(40 * 3000);
    mismatches++;
    summarize();
  end

  initial
  begin
    repeat (5) @(negedge clk_in);
    rstn_in = 1;
    check({7'h0, norm_ok_out}, 8'h01);
    power_on();
    short_outage();
    full_cycle();
    mid_reset();
    summarize();
  end
endmodule
